// file: hw/flash_host_pkg.sv
// Purpose: shared constants and carriers for the flash self-program host
// Assumes: 32-bit AXI4-Lite register bus, 20 MHz aclk
// Notes:   device pins travel as two packed structs
package flash_host_pkg;

  // register byte offsets on the AXI4-Lite bus
  localparam logic [4:0] OFS_CMD    = 5'h00;
  localparam logic [4:0] OFS_PTR    = 5'h04;
  localparam logic [4:0] OFS_DATA   = 5'h08;
  localparam logic [4:0] OFS_CTRL   = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;

  // command codes written to the command register
  localparam logic [1:0] OP_LOAD  = 2'h0;
  localparam logic [1:0] OP_ERASE = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [1:0] OP_REEN  = 2'h3;

  // control patterns presented on the self_prog_ctrl_reg port
  localparam logic [7:0] PAT_LOAD  = 8'h01;
  localparam logic [7:0] PAT_ERASE = 8'h03;
  localparam logic [7:0] PAT_WRITE = 8'h05;
  localparam logic [7:0] PAT_REEN  = 8'h11;
  localparam int         IRQ_EN_BIT = 7;

  // control register fields
  localparam int CTRL_IRQ_EN = 0;
  localparam int CTRL_GIE    = 1;

  // status register fields
  localparam int ST_BUSY   = 0;
  localparam int ST_SPE    = 1;
  localparam int ST_SBUSY  = 2;
  localparam int ST_HALT   = 3;
  localparam int ST_IRQ    = 4;
  localparam int ST_E_REF  = 8;
  localparam int ST_E_ORD  = 9;
  localparam int ST_E_DUP  = 10;

  // arm window: store strobe follows the control write by ARM_GAP cycles
  localparam int ARM_WINDOW = 4;
  localparam int ARM_GAP    = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // pins driven toward the sequencer
  typedef struct packed {
    logic        ctrl_wr;
    logic [7:0]  ctrl_val;
    logic        spm_stb;
    logic [15:0] zptr;
    logic [15:0] data_pair;
    logic        global_irq;
  } dev_cmd_s;

  // pins returned by the sequencer
  typedef struct packed {
    logic self_prog_enable;
    logic section_busy_flag;
    logic cpu_halt;
    logic ready_irq;
  } dev_stat_s;

endpackage

// file: hw/load_tracker.sv
// Purpose: remembers which buffer words were loaded since the last clear
// Assumes: one mark or clear per cycle at most
// Notes:   clear wins over mark
`timescale 1ns/100ps
module load_tracker
  import flash_host_pkg::*;
#(
  parameter int WORD_BITS = 6
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 clear,
  input  wire logic                 mark,
  input  wire logic [WORD_BITS-1:0] set_idx,
  input  wire logic [WORD_BITS-1:0] chk_idx,
  output logic                      dup
);
  localparam int WORDS = 1 << WORD_BITS;

  logic [WORDS-1:0] loaded;
  logic [WORDS-1:0] next_loaded;

  // one flag per buffer word
  genvar i;
  generate
    for (i = 0; i < WORDS; i++) begin : g_word
      always_comb begin
        next_loaded[i] = loaded[i];
        if (clear) begin
          next_loaded[i] = 1'b0;
        end else if (mark && set_idx == WORD_BITS'(i)) begin
          next_loaded[i] = 1'b1;
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          loaded[i] <= 1'b0;
        end else begin
          loaded[i] <= next_loaded[i];
        end
      end
    end
  endgenerate

  assign dup = loaded[chk_idx];

  // a completed load must land on a word not yet loaded
  no_dup_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mark |-> !loaded[set_idx])
    else $error("buffer word loaded twice");
endmodule

// file: hw/page_guard.sv
// Purpose: remembers the page erased last and not yet written
// Assumes: page number from the page_index_field of the pointer
// Notes:   a completed page write retires the erased page
`timescale 1ns/100ps
module page_guard
  import flash_host_pkg::*;
#(
  parameter int PAGE_BITS = 9
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 erase_done,
  input  wire logic                 write_done,
  input  wire logic [PAGE_BITS-1:0] done_page,
  input  wire logic [PAGE_BITS-1:0] chk_page,
  output logic                      page_ok
);
  logic                 erased;
  logic                 next_erased;
  logic [PAGE_BITS-1:0] page;
  logic [PAGE_BITS-1:0] next_page;

  // erased page bookkeeping
  always_comb begin
    next_erased = erased;
    next_page   = page;
    if (erase_done) begin
      next_erased = 1'b1;
      next_page   = done_page;
    end else if (write_done) begin
      next_erased = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erased <= 1'b0;
      page   <= '0;
    end else begin
      erased <= next_erased;
      page   <= next_page;
    end
  end

  assign page_ok = erased && (page == chk_page);

  // a completed write must match the erased page
  erase_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
    write_done |-> erased)
    else $error("page write completed without erase");
  same_page_a: assert property (@(posedge aclk) disable iff (!aresetn)
    write_done |-> page == done_page)
    else $error("page write address differs from erased page");
endmodule

// file: hw/flash_prog_host.sv
// Purpose: drives the flash self-program sequencer on behalf of software
// Assumes: AXI4-Lite slave for software, sequencer pins synchronous to aclk
// Notes:   one command at a time; refused commands answer SLVERR
`timescale 1ns/100ps
module flash_prog_host
  import flash_host_pkg::*;
#(
  parameter int WORD_BITS = 6,
  parameter int PTR_W     = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [4:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output dev_cmd_s         dev_cmd,
  input  wire dev_stat_s   dev_stat
);
  localparam int PAGE_BITS = PTR_W - 1 - WORD_BITS;
  // refuse layouts the pointer split cannot serve
  if (WORD_BITS < 1 || PAGE_BITS < 1 || PTR_W != 16 || ARM_GAP >= ARM_WINDOW) begin : g_bad
    $error("flash_prog_host: unsupported pointer layout");
  end
  typedef enum logic [1:0] {
    S_IDLE,
    S_ARM,
    S_STROBE,
    S_WAIT
  } seq_e;
  // bus and register state
  logic        aw_held, next_aw_held;
  logic        w_held, next_w_held;
  logic [4:0]  wr_addr, next_wr_addr;
  logic [31:0] wr_data, next_wr_data;
  logic [3:0]  wr_strb, next_wr_strb;
  logic        next_awready, next_wready, next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_arready, next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic [15:0] ptr, next_ptr;
  logic [15:0] data, next_data;
  logic [1:0]  ctrl, next_ctrl;
  logic [1:0]  last_op, next_last_op;
  logic [2:0]  errs, next_errs;
  // sequencer state
  seq_e        state, next_state;
  logic [1:0]  cur_op, next_cur_op;
  dev_cmd_s    next_cmd;
  logic                 do_write;
  logic                 cmd_hit;
  logic                 accept;
  logic                 op_idle;
  logic                 bad_order;
  logic                 bad_dup;
  logic [1:0]           wr_op;
  logic                 seq_done;
  logic                 dup;
  logic                 page_ok;
  logic [31:0]          status_word;
  logic [WORD_BITS-1:0] ptr_word;
  logic [PAGE_BITS-1:0] ptr_page;
  logic [WORD_BITS-1:0] cmd_word;
  logic [PAGE_BITS-1:0] cmd_page;
  // byte-lane merge for the pointer and data registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction
  // pointer split: bit 0 ignored, word index, then page index
  assign ptr_word = ptr[WORD_BITS:1];
  assign ptr_page = ptr[PTR_W-1:WORD_BITS+1];
  assign cmd_word = dev_cmd.zptr[WORD_BITS:1];
  assign cmd_page = dev_cmd.zptr[PTR_W-1:WORD_BITS+1];

  // command acceptance and refusal checks
  assign do_write  = aw_held && w_held && !bvalid;
  assign cmd_hit   = do_write && wr_addr == OFS_CMD && wr_strb[0];
  assign wr_op     = wr_data[1:0];
  assign op_idle   = state == S_IDLE;
  assign bad_order = wr_op == OP_WRITE && !page_ok;
  assign bad_dup   = wr_op == OP_LOAD && dup;
  assign accept    = cmd_hit && op_idle && !bad_order && !bad_dup;
  assign seq_done  = state == S_WAIT && !dev_stat.self_prog_enable;
  assign status_word = {21'h0, errs, 3'h0, dev_stat.ready_irq, dev_stat.cpu_halt,
                        dev_stat.section_busy_flag, dev_stat.self_prog_enable, !op_idle};
  // AXI4-Lite slave and software registers
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_awready = !aw_held && !(awvalid && awready);
    next_wready  = !w_held && !(wvalid && wready);
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_arready = arready;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    next_ptr     = ptr;
    next_data    = data;
    next_ctrl    = ctrl;
    next_last_op = last_op;
    next_errs    = errs;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_wr_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held  = 1'b1;
      next_wr_data = wdata;
      next_wr_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid  = 1'b0;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    if (do_write) begin
      next_bvalid = 1'b1;
      next_bresp  = RESP_OKAY;
      case (wr_addr)
        OFS_CMD: begin
          if (accept) begin
            next_last_op = wr_op;
          end else if (cmd_hit) begin
            next_bresp = RESP_SLVERR;
          end
        end
        OFS_PTR: begin
          next_ptr = merge16(ptr, wr_data, wr_strb);
        end
        OFS_DATA: begin
          next_data = merge16(data, wr_data, wr_strb);
        end
        OFS_CTRL: begin
          if (wr_strb[0]) next_ctrl = wr_data[1:0];
        end
        OFS_STATUS: begin
          if (wr_strb[1]) next_errs = errs & ~wr_data[ST_E_DUP:ST_E_REF];
        end
        default: begin
          next_bresp = RESP_SLVERR;
        end
      endcase
    end
    // sticky errors: a new refusal wins over a clear
    if (cmd_hit && !op_idle) next_errs[0] = 1'b1;
    if (cmd_hit && op_idle && bad_order) next_errs[1] = 1'b1;
    if (cmd_hit && op_idle && bad_dup) next_errs[2] = 1'b1;
    // read channel
    if (rvalid && rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
    if (arvalid && arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = RESP_OKAY;
      case (araddr)
        OFS_CMD:    next_rdata = {30'h0, last_op};
        OFS_PTR:    next_rdata = {16'h0, ptr};
        OFS_DATA:   next_rdata = {16'h0, data};
        OFS_CTRL:   next_rdata = {30'h0, ctrl};
        OFS_STATUS: next_rdata = status_word;
        default: begin
          next_rdata = 32'h0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    if (!next_rvalid && !(arvalid && arready)) next_arready = 1'b1; // read channel idle
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_addr <= 5'h0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
      ptr     <= 16'h0;
      data    <= 16'h0;
      ctrl    <= 2'h0;
      last_op <= OP_LOAD;
      errs    <= 3'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      ptr     <= next_ptr;
      data    <= next_data;
      ctrl    <= next_ctrl;
      last_op <= next_last_op;
      errs    <= next_errs;
    end
  end

  // sequencer: control write, store strobe, wait for the enable to drop
  always_comb begin
    next_state          = state;
    next_cur_op         = cur_op;
    next_cmd            = dev_cmd;
    next_cmd.ctrl_wr    = 1'b0;
    next_cmd.spm_stb    = 1'b0;
    next_cmd.global_irq = ctrl[CTRL_GIE];
    case (state)
      S_IDLE: begin
        if (accept) begin
          next_cur_op      = wr_op;
          next_cmd.ctrl_wr = 1'b1;
          next_cmd.zptr    = ptr;
          next_state       = S_ARM;
          case (wr_op)
            OP_LOAD:  next_cmd.ctrl_val = PAT_LOAD;
            OP_ERASE: next_cmd.ctrl_val = PAT_ERASE;
            OP_WRITE: next_cmd.ctrl_val = PAT_WRITE;
            default:  next_cmd.ctrl_val = PAT_REEN;
          endcase
          if (wr_op == OP_WRITE || wr_op == OP_ERASE) next_cmd.zptr = {ptr_page, {(WORD_BITS + 1){1'b0}}};
          if (wr_op != OP_REEN) next_cmd.ctrl_val[IRQ_EN_BIT] = ctrl[CTRL_IRQ_EN];
          next_cmd.data_pair = data;
        end
      end
      S_ARM: begin
        next_cmd.spm_stb = 1'b1;
        next_state       = S_STROBE;
      end
      S_STROBE: begin
        next_state = S_WAIT;
      end
      S_WAIT: begin
        if (!dev_stat.self_prog_enable) next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state   <= S_IDLE;
      cur_op  <= OP_LOAD;
      dev_cmd <= '0;
    end else begin
      state   <= next_state;
      cur_op  <= next_cur_op;
      dev_cmd <= next_cmd;
    end
  end
  load_tracker #(
    .WORD_BITS (WORD_BITS)
  ) u_loads (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (seq_done && (cur_op == OP_WRITE || cur_op == OP_REEN)),
    .mark    (seq_done && cur_op == OP_LOAD),
    .set_idx (cmd_word),
    .chk_idx (ptr_word),
    .dup     (dup)
  );
  page_guard #(
    .PAGE_BITS (PAGE_BITS)
  ) u_pages (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .erase_done (seq_done && cur_op == OP_ERASE),
    .write_done (seq_done && cur_op == OP_WRITE),
    .done_page  (cmd_page),
    .chk_page   (ptr_page),
    .page_ok    (page_ok)
  );
  // checks on the pin sequence
  strobe_follows_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dev_cmd.ctrl_wr |=> dev_cmd.spm_stb && $stable(dev_cmd.zptr)) else $error("store strobe missed the arm window");
  load_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dev_cmd.ctrl_wr && dev_cmd.ctrl_val[4:0] == PAT_LOAD[4:0] |=> dev_cmd.spm_stb && $stable(dev_cmd.data_pair))
    else $error("load data changed before store");
  write_ptr_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dev_cmd.ctrl_wr && dev_cmd.ctrl_val[4:0] == PAT_WRITE[4:0] |-> dev_cmd.zptr[WORD_BITS:0] == '0)
    else $error("page write pointer has word bits set");
  single_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dev_cmd.spm_stb |=> !dev_cmd.spm_stb [*2]) else $error("more than one store per command");
  quiet_while_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dev_stat.self_prog_enable && state == S_WAIT |=> !dev_cmd.ctrl_wr)
    else $error("command issued while programming");
  reenable_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dev_cmd.ctrl_wr && dev_cmd.ctrl_val == PAT_REEN |-> $past(!dev_stat.self_prog_enable))
    else $error("reenable issued while programming");
endmodule

// file: verif/flash_seq_model.sv
// Purpose: behavioural self-program sequencer seen from the host pins
// Assumes: pins synchronous to aclk, one command at a time
// Notes:   DUR stands in for erase/write time; pages from HALT_FIRST up halt the cpu
`timescale 1ns/100ps
module flash_seq_model
  import flash_host_pkg::*;
#(
  parameter int         DUR        = 40,
  parameter logic [8:0] HALT_FIRST = 9'h1c0
) (
  input  wire logic     aclk,
  input  wire logic     aresetn,
  input  wire dev_cmd_s cmd,
  output dev_stat_s     stat,
  output logic          dup_seen
);
  logic [2:0]  arm_cnt;
  logic [4:0]  arm_pat;
  logic [7:0]  busy_cnt;
  logic        spe;
  logic        sbusy;
  logic        halt;
  logic [63:0] loaded;

  assign stat = {spe, sbusy, halt, cmd.ctrl_val[IRQ_EN_BIT] & cmd.global_irq & ~spe};

  // arm window, store handling, timed erase and write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {arm_cnt, arm_pat, busy_cnt, spe, sbusy, halt, loaded, dup_seen} <= '0;
    end else if (busy_cnt != 8'h00) begin
      busy_cnt <= busy_cnt - 8'h01;
      if (busy_cnt == 8'h01) begin
        spe  <= 1'b0;
        halt <= 1'b0;
        if (arm_pat == 5'b00101) loaded <= '0;
      end
    end else if (cmd.ctrl_wr) begin
      if (cmd.ctrl_val[4:0] inside {5'b10001, 5'b01001, 5'b00101, 5'b00011, 5'b00001}) begin
        spe     <= 1'b1;
        arm_cnt <= 3'h4;
        arm_pat <= cmd.ctrl_val[4:0];
      end
    end else if (spe && cmd.spm_stb) begin
      arm_cnt <= 3'h0;
      case (arm_pat)
        5'b00001: begin
          spe      <= 1'b0;
          sbusy    <= 1'b0;
          dup_seen <= dup_seen | loaded[cmd.zptr[6:1]];
          loaded[cmd.zptr[6:1]] <= 1'b1;
        end
        5'b00011, 5'b00101: begin
          busy_cnt <= DUR[7:0];
          if (cmd.zptr[15:7] >= HALT_FIRST) halt <= 1'b1;
          else sbusy <= 1'b1;
        end
        5'b10001: begin
          spe    <= 1'b0;
          sbusy  <= 1'b0;
          loaded <= '0;
        end
        default: spe <= 1'b0;
      endcase
    end else if (arm_cnt != 3'h0) begin
      arm_cnt <= arm_cnt - 3'h1;
      if (arm_cnt == 3'h1) spe <= 1'b0;
    end
  end
endmodule

// file: verif/flash_prog_host_tb.sv
// Purpose: self-checking bench for the flash self-program host
// Assumes: sequencer model on the pin side, AXI4-Lite master tasks
// Notes:   random pages, words and data from a fixed seed
`timescale 1ns/100ps
module flash_prog_host_tb;
  import flash_host_pkg::*;
  localparam logic [8:0] HALT_FIRST = 9'h1c0;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, dup_seen, irq_en, prev_wr;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  cap_val;
  logic [15:0] cap_ptr, cap_dat;
  logic [8:0]  pg;
  logic [5:0]  w0;
  dev_cmd_s    dev_cmd;
  dev_stat_s   dev_stat;
  int          n_fail, tests_run, n_pulse;

  flash_prog_host #(.WORD_BITS(6), .PTR_W(16)) i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .dev_cmd(dev_cmd), .dev_stat(dev_stat));
  flash_seq_model #(.DUR(40), .HALT_FIRST(HALT_FIRST)) i_dev (.aclk(aclk), .aresetn(aresetn), .cmd(dev_cmd),
    .stat(dev_stat), .dup_seen(dup_seen));

  // 50 ns clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // write: address and data offered together, bready held until bvalid
  task automatic axw(input logic [4:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // read: rready held until rvalid
  task automatic axr(input logic [4:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  function automatic logic [7:0] pat(input logic [1:0] op);
    case (op)
      OP_LOAD:  return PAT_LOAD | {irq_en, 7'h00};
      OP_ERASE: return PAT_ERASE | {irq_en, 7'h00};
      OP_WRITE: return PAT_WRITE | {irq_en, 7'h00};
      default:  return PAT_REEN;
    endcase
  endfunction

  task automatic wait_idle();
    do begin
      axr(OFS_STATUS, d, r);
    end while (d[ST_BUSY] !== 1'b0);
  endtask

  // one command through the registers, with pin and status checks
  task automatic run(input logic [1:0] op, input logic [15:0] p, input logic [15:0] v, input logic [1:0] er,
                     input int eb);
    int          n0;
    logic [31:0] st;
    n0 = n_pulse;
    axw(OFS_PTR, {16'h0, p}, r);
    axw(OFS_DATA, {16'h0, v}, r);
    axw(OFS_CMD, {30'h0, op}, r);
    chk("bresp", {30'h0, er}, {30'h0, r});
    if (er != RESP_OKAY) begin
      axr(OFS_STATUS, st, r);
      chk("error flag", 32'h1, {31'h0, st[eb]});
      axw(OFS_STATUS, 32'h0000_0700, r);
      chk("no pulse", 32'(n0), 32'(n_pulse));
    end else begin
      if (op == OP_ERASE || op == OP_WRITE) begin
        axw(OFS_CMD, {30'h0, OP_LOAD}, r);
        chk("busy refuse", {30'h0, RESP_SLVERR}, {30'h0, r});
        axw(OFS_STATUS, 32'h0000_0700, r);
        axr(OFS_STATUS, st, r);
        chk("busy view", {28'h0, p[15:7] >= HALT_FIRST, p[15:7] < HALT_FIRST, 2'b11}, {28'h0, st[3:0]});
      end
      wait_idle();
      chk("one pulse", 32'(n0 + 1), 32'(n_pulse));
      chk("pattern", {24'h0, pat(op)}, {24'h0, cap_val});
      if (op == OP_LOAD)
        chk("word data", {10'h0, p[6:1], v}, {10'h0, cap_ptr[6:1], cap_dat});
      else if (op != OP_REEN)
        chk("page only", {16'h0, p[15:7], 7'h0}, {16'h0, cap_ptr});
    end
  endtask

  // pin monitor: latch each command, store strobe one cycle after it
  always @(posedge aclk) begin
    if (dev_cmd.ctrl_wr === 1'b1) begin
      n_pulse++;
      cap_val = dev_cmd.ctrl_val;
      cap_ptr = dev_cmd.zptr;
      cap_dat = dev_cmd.data_pair;
    end
    if (prev_wr === 1'b1 || dev_cmd.spm_stb === 1'b1)
      chk("store strobe", {31'h0, prev_wr}, {31'h0, dev_cmd.spm_stb});
    prev_wr = dev_cmd.ctrl_wr;
  end

  // watchdog, about forty times the expected run
  initial begin
    #1000000;
    n_fail++;
    $display("[ERR] watchdog expected done seen hang");
    summarize();
  end

  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, irq_en, prev_wr} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    n_fail = 0;
    tests_run = 0;
    n_pulse = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    void'($urandom(24872));
    axr(OFS_STATUS, d, r);
    chk("status reset", 32'h0, d);
    axr(5'h14, d, r);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped rdata", 32'h0, d);
    axw(5'h18, 32'h1, r);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    irq_en = 1'b1;
    axw(OFS_CTRL, 32'h3, r);
    pg = 9'($urandom % 448);
    w0 = 6'($urandom);
    for (int k = 0; k < 6; k++)
      run(OP_LOAD, {pg, w0 + 6'(k * 37), 1'b0}, 16'($urandom), RESP_OKAY, 0);
    axr(OFS_STATUS, d, r);
    chk("ready irq", 32'h1, {31'h0, d[ST_IRQ]});
    run(OP_LOAD, {pg, w0, 1'b1}, 16'h5a5a, RESP_SLVERR, ST_E_DUP);
    run(OP_WRITE, {pg, 7'h0}, 16'h0, RESP_SLVERR, ST_E_ORD);
    run(OP_ERASE, {pg, 7'h5b}, 16'hffff, RESP_OKAY, 0);
    run(OP_WRITE, {pg + 9'h1, 7'h0}, 16'h0, RESP_SLVERR, ST_E_ORD);
    run(OP_WRITE, {pg, 7'h0}, 16'h0, RESP_OKAY, 0);
    axr(OFS_STATUS, d, r);
    chk("section busy held", 32'h1, {31'h0, d[ST_SBUSY]});
    run(OP_LOAD, {pg, w0, 1'b0}, 16'h1234, RESP_OKAY, 0);
    axr(OFS_STATUS, d, r);
    chk("load clears busy", 32'h0, {31'h0, d[ST_SBUSY]});
    run(OP_REEN, 16'h0, 16'h0, RESP_OKAY, 0);
    run(OP_LOAD, {pg, w0, 1'b0}, 16'h4321, RESP_OKAY, 0);
    irq_en = 1'b0;
    axw(OFS_CTRL, 32'h2, r);
    pg = HALT_FIRST + 9'($urandom % 64);
    run(OP_ERASE, {pg, 7'h0}, 16'h0, RESP_OKAY, 0);
    run(OP_LOAD, {pg, w0 + 6'h1, 1'b0}, 16'($urandom), RESP_OKAY, 0);
    run(OP_WRITE, {pg, 7'h0}, 16'h0, RESP_OKAY, 0);
    axr(OFS_STATUS, d, r);
    chk("irq masked", 32'h0, {31'h0, d[ST_IRQ]});
    chk("double load", 32'h0, {31'h0, dup_seen});
    summarize();
  end
endmodule
